// [ptp_ts_cfg.svh]
// constants for the ptp time stamp rewrite block
`ifndef PTP_TS_CFG_SVH
`define PTP_TS_CFG_SVH
// ****************************************
// register map (byte addresses)
// ****************************************
`define REG_CTRL 8'h00
`define REG_LATENCY 8'h04
`define REG_ASYM 8'h08
`define REG_ID_OFS 8'h0C
`define REG_STATUS 8'h10
`define REG_FIFO_ID 8'h14
`define REG_FIFO_TS 8'h18
`define CTRL_EN 0
`define CTRL_EGR 1
`define CTRL_MODE 3:2
`define CTRL_DOM 15:8
`define CTRL_RESET 32'h0000_0000
`define STATUS_OVF 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ****************************************
// frame layout, byte index from first dest byte
// ****************************************
`define POS_ETH_HI 6'h0C
`define POS_ETH_LO 6'h0D
`define POS_MSGTYPE 6'h0E
`define POS_DOMAIN 6'h12
`define POS_CF 6'h16
`define POS_CF_LAST 6'h1D
`define POS_RES 6'h1E
`define POS_RES_LAST 6'h21
`define POS_DECIDE 6'h21
`define POS_MAX 6'h3F
`define ETYPE_HI 8'h88
`define ETYPE_LO 8'hF7
`define MSG_SYNC 4'h0
`define MSG_DREQ 4'h1
`define ID_LEN 6'h04
// ****************************************
// sizes and arithmetic
// ****************************************
`define DELAY_DEPTH 40
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_POLY 32'hEDB8_8320
`define CRC_RESIDUE 32'hDEBB_20E3
`define NS_PER_SEC 32'h3B9A_CA00
`endif

// [ptp_pkg.sv]
// types shared by the ptp time stamp rewrite block
package ptp_pkg;
  typedef enum logic [1:0] {
    MODE_TWO_STEP = 2'h0,
    MODE_TC_A = 2'h1,
    MODE_TC_B = 2'h2
  } clk_mode_e;
  typedef enum logic [5:0] {
    ACT_NOP = 6'b000001,
    ACT_WRITE = 6'b000010,
    ACT_WRITE_SAVE = 6'b000100,
    ACT_SUBTRACT = 6'b001000,
    ACT_ADD = 6'b010000,
    ACT_MODEB_EGR = 6'b100000
  } action_e;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } beat_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic bad;
  } line_s;
  typedef struct packed {
    logic hit;
    logic wr_cf;
    logic wr_res;
    logic [63:0] cf;
    logic [31:0] res;
  } decision_s;
  typedef struct packed {
    logic [31:0] id;
    logic [31:0] ts;
  } fifo_entry_s;
endpackage

// [ptp_ts_rewrite.sv]
// per-direction ptp analyzer, time stamp unit, rewriter and tx stamp fifo
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`include "ptp_ts_cfg.svh"
module ptp_ts_rewrite (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // frame stream in, local ns time
  input wire ptp_pkg::beat_s i_in_beat,
  input wire logic [31:0] i_time_ns,
  // frame stream out
  output ptp_pkg::beat_s o_out_beat,
  // axi4-lite write
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  // axi4-lite read
  input wire logic [7:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready
);
  import ptp_pkg::*;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int b = 0; b < 8; b++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [31:0] latency_reg;
  logic [31:0] asym_reg;
  logic [5:0] id_ofs_reg;
  logic ovf_reg;
  wire logic enable = ctrl_reg[`CTRL_EN];
  wire logic egress = ctrl_reg[`CTRL_EGR];
  wire clk_mode_e mode = clk_mode_e'(ctrl_reg[`CTRL_MODE]);
  wire logic [7:0] domain = ctrl_reg[`CTRL_DOM];

  // ****************************************
  // analyzer: byte position and field capture
  // ****************************************
  logic in_mid_reg;
  logic [5:0] in_pos_reg;
  logic [31:0] ts_cap_reg;
  logic [31:0] crc_in_reg;
  logic etype_ok_reg;
  logic [3:0] msg_reg;
  logic dom_ok_reg;
  logic [63:0] cf_reg;
  logic [23:0] res_reg;
  logic [31:0] id_reg;
  decision_s dec_reg;
  wire logic in_v = i_in_beat.valid;
  wire logic [7:0] in_d = i_in_beat.data;
  wire logic in_first = in_v && !in_mid_reg;
  wire logic [5:0] in_pos = in_first ? 6'h00 : in_pos_reg;
  wire logic [5:0] in_pos_inc = (in_pos == `POS_MAX) ? `POS_MAX : in_pos + 6'h01;
  wire logic [31:0] crc_in = crc_byte(in_first ? `CRC_INIT : crc_in_reg, in_d);
  wire logic in_bad = i_in_beat.last && (crc_in != `CRC_RESIDUE);
  wire logic in_cf = in_pos >= `POS_CF && in_pos <= `POS_CF_LAST;
  wire logic in_id = in_pos >= id_ofs_reg && in_pos < id_ofs_reg + `ID_LEN;
  wire logic decide = in_v && in_pos == `POS_DECIDE;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_mid_reg <= 1'b0;
      in_pos_reg <= 6'h00;
      crc_in_reg <= `CRC_INIT;
    end else if (in_v) begin
      in_mid_reg <= !i_in_beat.last;
      in_pos_reg <= in_pos_inc;
      crc_in_reg <= crc_in;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ts_cap_reg <= 32'h0;
      etype_ok_reg <= 1'b0;
      msg_reg <= 4'h0;
      dom_ok_reg <= 1'b0;
      cf_reg <= 64'h0;
      res_reg <= 24'h0;
      id_reg <= 32'h0;
    end else if (in_v) begin
      if (in_first) ts_cap_reg <= i_time_ns;
      if (in_pos == `POS_ETH_HI) etype_ok_reg <= in_d == `ETYPE_HI;
      if (in_pos == `POS_ETH_LO) etype_ok_reg <= etype_ok_reg && in_d == `ETYPE_LO;
      if (in_pos == `POS_MSGTYPE) msg_reg <= in_d[3:0];
      if (in_pos == `POS_DOMAIN) dom_ok_reg <= in_d == domain;
      if (in_cf) cf_reg <= {cf_reg[55:0], in_d};
      if (in_pos >= `POS_RES) res_reg <= {res_reg[15:0], in_d};
      if (in_id) id_reg <= {id_reg[23:0], in_d};
    end
  end

  // ****************************************
  // time stamp unit
  // ****************************************
  wire logic is_sync = msg_reg == `MSG_SYNC;
  wire logic is_dreq = msg_reg == `MSG_DREQ;
  wire logic match = enable && etype_ok_reg && dom_ok_reg && (is_sync || is_dreq);
  wire logic [31:0] res_full = {res_reg, in_d};
  wire logic [31:0] t_rx = ts_cap_reg - latency_reg;
  wire logic [31:0] t_tx = ts_cap_reg + latency_reg;
  // reserved bytes hold sub-second ns, so a second boundary needs folding back
  wire logic [31:0] resid = (t_tx - res_full) + ((t_tx < res_full) ? `NS_PER_SEC : 32'h0);
  wire logic asym_app = egress ? is_dreq : is_sync;
  wire logic [63:0] asym64 = {{16{asym_reg[31]}}, asym_reg, 16'h0};
  wire logic [63:0] asym_term = !asym_app ? 64'h0 : egress ? -asym64 : asym64;
  wire logic [63:0] cf_base = cf_reg + asym_term;
  wire logic [63:0] cf_sub = cf_base - {16'h0, t_rx, 16'h0};
  wire logic [63:0] cf_add = cf_base + {16'h0, t_tx, 16'h0};
  wire logic [63:0] cf_modeb = cf_base + {16'h0, resid, 16'h0};
  wire action_e act = action_e'(
    !match ? ACT_NOP :
    (mode == MODE_TC_A) ? (egress ? ACT_ADD : ACT_SUBTRACT) :
    (mode == MODE_TC_B && egress) ? ACT_MODEB_EGR :
    egress ? ACT_WRITE_SAVE : ACT_WRITE);
  wire logic act_cf_only = act == ACT_SUBTRACT || act == ACT_ADD || act == ACT_MODEB_EGR;
  decision_s dec_next;
  assign dec_next.hit = act != ACT_NOP;
  assign dec_next.wr_res = act == ACT_WRITE || act == ACT_MODEB_EGR;
  assign dec_next.wr_cf = act_cf_only || (dec_next.hit && asym_app);
  assign dec_next.cf = (act == ACT_SUBTRACT) ? cf_sub : (act == ACT_ADD) ? cf_add :
                       (act == ACT_MODEB_EGR) ? cf_modeb : cf_base;
  assign dec_next.res = (act == ACT_WRITE) ? t_rx : 32'h0;

  // a frame too short to reach the decision point keeps hit low
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dec_reg <= '0;
    end else if (in_first) begin
      dec_reg <= '0;
    end else if (decide) begin
      dec_reg <= dec_next;
    end
  end

  // ****************************************
  // delay line: holds bytes until the decision is known
  // ****************************************
  line_s dl_reg [`DELAY_DEPTH];
  logic [3:0] tail_hit;
  logic [3:0] tail_bad;
  genvar g;
  generate
    for (g = 0; g < `DELAY_DEPTH; g++) begin : g_dl
      line_s dl_src;
      if (g == 0) begin : g_first
        assign dl_src = {in_v, in_d, i_in_beat.last, in_bad};
      end else begin : g_next
        assign dl_src = dl_reg[g-1];
      end
      always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          dl_reg[g] <= '0;
        end else begin
          dl_reg[g] <= dl_src;
        end
      end
    end
    for (g = 0; g < 4; g++) begin : g_tail
      assign tail_hit[g] = dl_reg[`DELAY_DEPTH-1-g].valid && dl_reg[`DELAY_DEPTH-1-g].last;
      assign tail_bad[g] = tail_hit[g] && dl_reg[`DELAY_DEPTH-1-g].bad;
    end
  endgenerate

  // ****************************************
  // rewriter
  // ****************************************
  line_s head;
  assign head = dl_reg[`DELAY_DEPTH-1];
  logic out_mid_reg;
  logic [5:0] out_pos_reg;
  decision_s out_dec_reg;
  logic [31:0] crc_out_reg;
  beat_s out_reg;
  wire logic out_first = head.valid && !out_mid_reg;
  wire logic [5:0] out_pos = out_first ? 6'h00 : out_pos_reg;
  wire decision_s odec = out_first ? dec_reg : out_dec_reg;
  wire logic in_fcs = |tail_hit;
  wire logic [1:0] fcs_k = tail_hit[0] ? 2'h3 : tail_hit[1] ? 2'h2 : tail_hit[2] ? 2'h1 : 2'h0;
  wire logic [5:0] cf_sel = `POS_CF_LAST - out_pos;
  wire logic [5:0] res_sel = `POS_RES_LAST - out_pos;
  wire logic at_cf = odec.wr_cf && out_pos >= `POS_CF && out_pos <= `POS_CF_LAST;
  wire logic at_res = odec.wr_res && out_pos >= `POS_RES && out_pos <= `POS_RES_LAST;
  wire logic modified = odec.wr_cf || odec.wr_res;
  wire logic [7:0] body_byte = at_cf ? odec.cf[{cf_sel[2:0], 3'h0} +: 8] :
                               at_res ? odec.res[{res_sel[1:0], 3'h0} +: 8] :
                               head.data;
  wire logic [31:0] crc_run = out_first ? `CRC_INIT : crc_out_reg;
  // fcs goes out low byte first; left uninverted for a bad input frame so the frame stays bad
  wire logic [7:0] fcs_byte = crc_run[{fcs_k, 3'h0} +: 8] ^ ((|tail_bad) ? 8'h00 : 8'hFF);
  wire logic [7:0] out_byte = (modified && in_fcs) ? fcs_byte : body_byte;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_mid_reg <= 1'b0;
      out_pos_reg <= 6'h00;
      out_dec_reg <= '0;
      crc_out_reg <= `CRC_INIT;
    end else if (head.valid) begin
      out_mid_reg <= !head.last;
      out_pos_reg <= (out_pos == `POS_MAX) ? `POS_MAX : out_pos + 6'h01;
      out_dec_reg <= odec;
      crc_out_reg <= in_fcs ? crc_run : crc_byte(crc_run, out_byte);
    end
  end

  // one byte out for every byte in: length never changes
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_reg <= '0;
    end else begin
      out_reg <= {head.valid, out_byte, head.last};
    end
  end
  assign o_out_beat = out_reg;

  // ****************************************
  // tx time stamp fifo
  // ****************************************
  fifo_entry_s fifo_mem_reg [`FIFO_DEPTH];
  logic [`FIFO_AW:0] wr_ptr_reg;
  logic [`FIFO_AW:0] rd_ptr_reg;
  wire logic [`FIFO_AW:0] fifo_cnt = wr_ptr_reg - rd_ptr_reg;
  wire logic fifo_full = fifo_cnt[`FIFO_AW];
  wire logic fifo_empty = fifo_cnt == '0;
  // sequence id lies past the decision point: the entry waits for the last byte
  logic save_pend_reg;
  wire logic save_req = decide && act == ACT_WRITE_SAVE;
  wire logic push_req = save_pend_reg && in_v && i_in_beat.last;
  wire logic push = push_req && !fifo_full;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      save_pend_reg <= 1'b0;
    end else if (save_req) begin
      save_pend_reg <= 1'b1;
    end else if (in_first || push_req) begin
      save_pend_reg <= 1'b0;
    end
  end
  wire fifo_entry_s fifo_head = fifo_mem_reg[rd_ptr_reg[`FIFO_AW-1:0]];
  logic pop;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      fifo_mem_reg[wr_ptr_reg[`FIFO_AW-1:0]] <= '{id: id_reg, ts: t_tx};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (`FIFO_AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (`FIFO_AW+1)'(pop);
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  wire logic aw_hs = i_axi_awvalid && awready_reg;
  wire logic w_hs = i_axi_wvalid && wready_reg;
  wire logic ar_hs = i_axi_arvalid && arready_reg;
  wire logic wr_go = !awready_reg && !wready_reg && !bvalid_reg;
  wire logic wr_map = awaddr_reg == `REG_CTRL || awaddr_reg == `REG_LATENCY ||
                      awaddr_reg == `REG_ASYM || awaddr_reg == `REG_ID_OFS ||
                      awaddr_reg == `REG_STATUS;
  wire logic ovf_clr = wr_go && awaddr_reg == `REG_STATUS && wstrb_reg[1] &&
                       wdata_reg[`STATUS_OVF];
  wire logic rd_map = wr_map_r(i_axi_araddr);
  wire logic [31:0] rd_data =
    (i_axi_araddr == `REG_CTRL) ? ctrl_reg :
    (i_axi_araddr == `REG_LATENCY) ? latency_reg :
    (i_axi_araddr == `REG_ASYM) ? asym_reg :
    (i_axi_araddr == `REG_ID_OFS) ? {26'h0, id_ofs_reg} :
    (i_axi_araddr == `REG_STATUS) ? {23'h0, ovf_reg, 4'h0, 4'(fifo_cnt)} :
    (i_axi_araddr == `REG_FIFO_ID) ? fifo_head.id :
    (i_axi_araddr == `REG_FIFO_TS) ? fifo_head.ts : 32'h0;
  // reading the stamp word retires the entry; read the id first
  assign pop = ar_hs && i_axi_araddr == `REG_FIFO_TS && !fifo_empty;

  function automatic logic wr_map_r(input logic [7:0] a);
    return a == `REG_CTRL || a == `REG_LATENCY || a == `REG_ASYM || a == `REG_ID_OFS ||
           a == `REG_STATUS || a == `REG_FIFO_ID || a == `REG_FIFO_TS;
  endfunction

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_reg <= 1'b0;
        awaddr_reg <= {i_axi_awaddr[7:2], 2'h0};
      end
      if (w_hs) begin
        wready_reg <= 1'b0;
        wdata_reg <= i_axi_wdata;
        wstrb_reg <= i_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_reg && i_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= `CTRL_RESET;
      latency_reg <= 32'h0;
      asym_reg <= 32'h0;
      id_ofs_reg <= 6'h00;
    end else if (wr_go) begin
      if (awaddr_reg == `REG_CTRL) ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
      if (awaddr_reg == `REG_LATENCY) latency_reg <= merge(latency_reg, wdata_reg, wstrb_reg);
      if (awaddr_reg == `REG_ASYM) asym_reg <= merge(asym_reg, wdata_reg, wstrb_reg);
      if (awaddr_reg == `REG_ID_OFS && wstrb_reg[0]) id_ofs_reg <= wdata_reg[5:0];
    end
  end

  // overflow: a dropped push in the clearing cycle keeps the flag set
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= (push_req && fifo_full) || (ovf_reg && !ovf_clr);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `RESP_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_reg && i_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  assign o_axi_awready = awready_reg;
  assign o_axi_wready = wready_reg;
  assign o_axi_bvalid = bvalid_reg;
  assign o_axi_bresp = bresp_reg;
  assign o_axi_arready = arready_reg;
  assign o_axi_rvalid = rvalid_reg;
  assign o_axi_rdata = rdata_reg;
  assign o_axi_rresp = rresp_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  a_write_res_value: assert property (
    decide && act == ACT_WRITE && !in_first |=> dec_reg.wr_res && dec_reg.res == $past(t_rx))
    else $error("write action did not load receive time");
  a_subtract_cf: assert property (
    decide && act == ACT_SUBTRACT |=> dec_reg.wr_cf &&
    dec_reg.cf == $past(cf_reg) + $past(asym_term) - {16'h0, $past(t_rx), 16'h0})
    else $error("subtract result wrong");
  a_add_cf: assert property (
    decide && act == ACT_ADD |=> dec_reg.cf == $past(cf_base) + {16'h0, $past(t_tx), 16'h0})
    else $error("add result wrong");
  a_modeb_clear: assert property (
    decide && act == ACT_MODEB_EGR |=> dec_reg.wr_res && dec_reg.res == 32'h0 && dec_reg.wr_cf)
    else $error("mode b did not clear reserved bytes");
  a_save_push: assert property (
    push |=> wr_ptr_reg == $past(wr_ptr_reg) + 1'b1 &&
    fifo_mem_reg[$past(wr_ptr_reg[`FIFO_AW-1:0])].ts == $past(ts_cap_reg + latency_reg))
    else $error("fifo entry not stored");
  a_fifo_order: assert property (
    pop |=> rd_ptr_reg == $past(rd_ptr_reg) + 1'b1 && rdata_reg == $past(fifo_head.ts))
    else $error("fifo read out of order");
  a_nop_passthru: assert property (
    head.valid && !modified |=> o_out_beat.valid && o_out_beat.data == $past(head.data))
    else $error("unmatched frame was altered");
  a_bad_fcs_kept: assert property (
    head.valid && modified && tail_hit[0] && tail_bad[0] |=>
    o_out_beat.data == $past(crc_run[31:24]))
    else $error("bad fcs not carried");
  a_length_kept: assert property (
    ##1 o_out_beat.valid == $past(head.valid) && o_out_beat.last == $past(head.last))
    else $error("frame length changed");
  c_two_step_save: cover property (push ##[1:200] pop);
  c_mode_b_frame: cover property (decide && act == ACT_MODEB_EGR);
  c_bad_modified: cover property (head.valid && modified && |tail_bad);
  c_fifo_overflow: cover property (push_req && fifo_full);
endmodule

// [mac_model.sv]
// frame source standing in for the system-side mac
module mac_model (
  // clock
  input wire logic i_clk,
  // frame stream toward the block
  output ptp_pkg::beat_s o_beat
);
  timeunit 1ns;
  timeprecision 1ns;
  import ptp_pkg::*;
  initial o_beat = '0;
  // ****************************************
  // one 64-byte raw ptp frame, filler byte = index
  // ****************************************
  task automatic send(input logic [3:0] msg, input logic [7:0] dom);
    logic [7:0] b;
    for (int i = 0; i < 64; i++) begin
      // sequence id sits at 44-45, inside the id window
      b = (i == 12) ? 8'h88 : (i == 13) ? 8'hF7 : (i == 14) ? {4'h0, msg} :
          (i == 18) ? dom : 8'(i);
      @(posedge i_clk);
      o_beat <= '{1'b1, b, i == 63};
    end
    @(posedge i_clk);
    // idle line must not look like a held byte
    o_beat <= '{1'b0, ~b, 1'b0};
  endtask
endmodule

// [tb_top.sv]
// register bus and frame checks of the ptp rewrite block
`include "ptp_ts_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ptp_pkg::*;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] bresp, rsp;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, t_ns = 32'h1000;
  beat_s in_b, out_b;
  logic [7:0] ob [64];
  logic [31:0] resid_exp;
  localparam logic [63:0] cf_orig = 64'h161718191A1B1C1D;
  int failures = 0, checks_done = 0, oi = 0;
  always #20 clk = ~clk;
  always @(posedge clk) if (out_b.valid) begin
    ob[oi] <= out_b.data;
    oi <= out_b.last ? 0 : oi + 1;
  end
  mac_model u_mac (.i_clk(clk), .o_beat(in_b));
  ptp_ts_rewrite u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_in_beat(in_b), .i_time_ns(t_ns),
    .o_out_beat(out_b), .i_axi_awaddr(awa), .i_axi_awvalid(awv), .o_axi_awready(awr),
    .i_axi_wdata(wd), .i_axi_wstrb(4'hF), .i_axi_wvalid(wv), .o_axi_wready(wrd),
    .o_axi_bresp(bresp), .o_axi_bvalid(bv), .i_axi_bready(bre), .i_axi_araddr(ara),
    .i_axi_arvalid(arv), .o_axi_arready(arr), .o_axi_rdata(rdat), .o_axi_rresp(rsp),
    .o_axi_rvalid(rv), .i_axi_rready(rre));
  // ****************************************
  // bus and frame helpers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    bre <= 0;
    `CHK(bresp, `RESP_OKAY)
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    ara <= a; arv <= 1; rre <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    rre <= 0;
    `CHK(rdat, e)
    `CHK(rsp, er)
  endtask
  // output lands 41 cycles after input, so 45 covers the tail
  task automatic fr(input logic [3:0] m, input logic [7:0] d);
    u_mac.send(m, d);
    repeat (45) @(posedge clk);
  endtask
  function automatic logic [63:0] fld(input int s, input int n);
    logic [63:0] r;
    r = '0;
    for (int k = 0; k < n; k++) r = {r[55:0], ob[s + k]};
    return r;
  endfunction
  // filler fcs makes every sent frame bad, so a rewritten fcs goes out uninverted
  function automatic logic [63:0] fcs_bad();
    logic [31:0] c;
    c = `CRC_INIT;
    for (int k = 0; k < 60; k++) begin
      c = c ^ {24'h0, ob[k]};
      for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    return {32'h0, c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    test_done;
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    rchk(`REG_CTRL, 32'h0, `RESP_OKAY);
    rchk(8'h40, 32'h0, `RESP_SLVERR);
    fr(4'h0, 8'h05);
    `CHK(fld(30, 4), 64'h1E1F2021)
    `CHK(fld(60, 4), 64'h3C3D3E3F)
    wr(`REG_LATENCY, 32'h100);
    wr(`REG_CTRL, 32'h501);
    fr(4'h0, 8'h05);
    `CHK(fld(30, 4), 64'(t_ns - 32'h100))
    // receiver writes the receive time into the stamp; bytes 34 to 41 past it must be as sent
    `CHK(fld(34, 8), 64'h2223242526272829)
    `CHK(fld(60, 4), fcs_bad())
    fr(4'h1, 8'h06);
    `CHK(fld(30, 4), 64'h1E1F2021)
    wr(`REG_ID_OFS, 32'h2C);
    wr(`REG_CTRL, 32'h503);
    fr(4'h1, 8'h05);
    rchk(`REG_STATUS, 32'h1, `RESP_OKAY);
    rchk(`REG_FIFO_ID, 32'h2C2D2E2F, `RESP_OKAY);
    rchk(`REG_FIFO_TS, t_ns + 32'h100, `RESP_OKAY);
    wr(`REG_CTRL, 32'h50B);
    fr(4'h0, 8'h05);
    // reserved filler lies above the tx time, so the residence wraps one second
    resid_exp = t_ns + 32'h100 + `NS_PER_SEC - 32'h1E1F2021;
    `CHK(fld(22, 8), cf_orig + {16'h0, resid_exp, 16'h0})
    `CHK(fld(30, 4), 64'h0)
    `CHK(fld(60, 4), fcs_bad())
    wr(`REG_CTRL, 32'h509);
    fr(4'h1, 8'h05);
    `CHK(fld(30, 4), 64'(t_ns - 32'h100))
    wr(`REG_ASYM, 32'h10);
    wr(`REG_CTRL, 32'h501);
    fr(4'h0, 8'h05);
    `CHK(fld(22, 8), cf_orig + 64'h10_0000)
    wr(`REG_CTRL, 32'h505);
    fr(4'h0, 8'h05);
    `CHK(fld(22, 8), cf_orig + 64'h10_0000 - {16'h0, t_ns - 32'h100, 16'h0})
    `CHK(fld(30, 4), 64'h1E1F2021)
    wr(`REG_CTRL, 32'h507);
    fr(4'h1, 8'h05);
    `CHK(fld(22, 8), cf_orig - 64'h10_0000 + {16'h0, t_ns + 32'h100, 16'h0})
    `CHK(fld(60, 4), fcs_bad())
    test_done;
  end
endmodule
